// >>> verilog/srx_pkg.sv
package srx_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_STATUS_A = 8'hC0;
  localparam logic [7:0] ADDR_CONTROL_B = 8'hC1;
  localparam logic [7:0] ADDR_FORMAT_C = 8'hC2;
  localparam logic [7:0] ADDR_DATA = 8'hC6;
  localparam logic [7:0] ADDR_BAUD_LO = 8'hC4;
  localparam logic [7:0] ADDR_BAUD_HI = 8'hC5;
  // Reset values
  localparam logic [7:0] STATUS_A_RESET = 8'h20;
  localparam logic [7:0] FORMAT_C_RESET = 8'h06;
  // Status A bit positions
  localparam int BIT_RX_DONE = 7;
  localparam int BIT_TX_DONE = 6;
  localparam int BIT_TX_EMPTY = 5;
  localparam int BIT_FRAME_ERR = 4;
  localparam int BIT_OVERRUN = 3;
  localparam int BIT_PAR_ERR = 2;
  localparam int BIT_DOUBLE = 1;
  localparam int BIT_ADDR_FILT = 0;
  // Control B bit positions
  localparam int BIT_RX_ENABLE = 4;
  localparam int BIT_SIZE2 = 2;
  localparam int BIT_RX9 = 1;
  // Format C bit positions
  localparam int BIT_PAR_EN = 5;
  localparam int BIT_PAR_ODD = 4;
  localparam int BIT_SIZE1 = 2;
  localparam int BIT_SIZE0 = 1;
  // Oversampling
  localparam logic [3:0] OVS_NORMAL_LAST = 4'hF;
  localparam logic [3:0] OVS_DOUBLE_LAST = 4'h7;
  localparam logic [3:0] MID_NORMAL = 4'h8;
  localparam logic [3:0] MID_DOUBLE = 4'h4;
  localparam logic [3:0] SIZE9_CODE = 4'h7;
  localparam logic [3:0] BASE_BITS = 4'h5;
  // One stored frame
  typedef struct packed {
    logic [8:0] data;
    logic frameErr;
    logic parErr;
    logic lost;
  } srx_entry_t;
  // APB request
  typedef struct packed {
    logic sel;
    logic enable;
    logic write;
    logic [7:0] addr;
    logic [31:0] wdata;
  } srx_apb_req_t;
endpackage

// >>> verilog/srx_receiver.sv
`timescale 1ns/1ps
module srx_receiver
  import srx_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line
  input wire logic serialIn,
  output logic pinOwned,
  // Transmitter hooks
  input wire logic txCompleteSet,
  input wire logic txBufferEmpty
);

  // Receiver states
  typedef enum logic [3:0] {
    S_IDLE = 4'b0001,
    S_START = 4'b0010,
    S_BITS = 4'b0100,
    S_STOP = 4'b1000
  } srx_state_t;

  srx_apb_req_t req;
  assign req = '{sel: psel, enable: penable, write: pwrite,
                 addr: paddr, wdata: pwdata};

  // Software registers
  logic [7:0] ctrlB_q;
  logic [7:0] fmtC_q;
  logic [11:0] baud_q;
  logic txDone_q;
  logic double_q;
  logic addrFilt_q;
  logic txEmpty_q;
  // Two entry receive buffer
  srx_entry_t buf_q [2];
  logic [1:0] count_q;
  logic head_q;
  // Synchroniser, three stages
  logic [2:0] sync_q;
  logic rxLevel_q;
  // Baud tick generator
  logic [11:0] baudCnt_q;
  logic tick;
  // Frame engine
  srx_state_t state_q;
  logic [3:0] sampCnt_q;
  logic [3:0] bitIdx_q;
  logic [8:0] shift_q;
  logic [2:0] vote_q;
  logic parRx_q;
  logic shiftFull_q;
  logic pendLost_q;
  logic [31:0] prdata_q;
  logic pready_q;

  // Decoded configuration
  logic receiver_enable_bit;
  logic [3:0] sizeCode;
  logic [3:0] nBits;
  logic nine;
  logic parEn;
  logic [3:0] lastSamp;
  logic [3:0] midSamp;
  assign receiver_enable_bit = ctrlB_q[BIT_RX_ENABLE];
  assign sizeCode = {1'b0, ctrlB_q[BIT_SIZE2], fmtC_q[BIT_SIZE1],
                     fmtC_q[BIT_SIZE0]};
  assign nine = (sizeCode == SIZE9_CODE);
  assign nBits = nine ? 4'h9 : 4'(sizeCode + BASE_BITS);
  assign parEn = fmtC_q[BIT_PAR_EN];
  assign lastSamp = double_q ? OVS_DOUBLE_LAST : OVS_NORMAL_LAST;
  assign midSamp = double_q ? MID_DOUBLE : MID_NORMAL;

  // APB decode
  logic access;
  logic wrEn;
  logic rdData;
  assign access = req.sel && req.enable && pready_q;
  assign wrEn = access && req.write;
  assign rdData = access && !req.write && (req.addr == ADDR_DATA);

  // Centre-sample majority and frame completion
  logic sampleNow;
  logic bitVal;
  logic [2:0] voteNext;
  // Centre sampling keeps the rate mismatch margin on both sides
  assign sampleNow = tick &&
    ((sampCnt_q == 4'(midSamp - 4'h1)) || (sampCnt_q == midSamp) ||
     (sampCnt_q == 4'(midSamp + 4'h1)));
  assign voteNext = sampleNow ? {vote_q[1:0], rxLevel_q} : vote_q;
  // Majority of the three centre samples rejects short glitches
  assign bitVal = (voteNext[0] & voteNext[1]) | (voteNext[0] & voteNext[2]) |
                  (voteNext[1] & voteNext[2]);
  logic bitDone;
  assign bitDone = tick && (sampCnt_q == lastSamp);
  logic frameDone;
  assign frameDone = (state_q == S_STOP) && bitDone && receiver_enable_bit;
  // Frame type marker and acceptance
  logic addrMark;
  assign addrMark = nine ? shift_q[8] : bitVal;
  logic accept;
  assign accept = frameDone && (!addrFilt_q || addrMark);
  // Parity: xor of data, inverted for odd
  logic parCalc;
  always_comb begin
    parCalc = fmtC_q[BIT_PAR_ODD];
    for (int i = 0; i < 9; i++) begin
      if (4'(i) < nBits) begin
        parCalc = parCalc ^ shift_q[i];
      end
    end
  end
  srx_entry_t newEntry;
  always_comb begin
    newEntry.data = nine ? shift_q : {1'b0, shift_q[7:0]};
    newEntry.frameErr = !bitVal;
    newEntry.parErr = parEn && (parCalc != parRx_q);
    newEntry.lost = pendLost_q;
  end
  logic startDetect;
  assign startDetect = (state_q == S_IDLE) && receiver_enable_bit && !rxLevel_q;

  // Input synchroniser, change taken when stages two and three agree
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_q <= 3'h7;
      rxLevel_q <= 1'b1;
    end else begin
      sync_q <= {sync_q[1:0], serialIn};
      if (sync_q[1] == sync_q[2]) begin
        rxLevel_q <= sync_q[2];
      end
    end
  end

  // Oversample tick: clock / (divisor + 1)
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      baudCnt_q <= 12'h000;
    end else if (baudCnt_q >= baud_q) begin
      baudCnt_q <= 12'h000;
    end else begin
      baudCnt_q <= 12'(baudCnt_q + 12'h001);
    end
  end
  assign tick = (baudCnt_q >= baud_q);

  // Frame engine, restarts its sample count on each start edge
  always_ff @(posedge clock) begin
    if (!rst_n || !receiver_enable_bit) begin
      state_q <= S_IDLE;
      sampCnt_q <= 4'h0;
      bitIdx_q <= 4'h0;
      shift_q <= 9'h000;
      vote_q <= 3'h7;
      parRx_q <= 1'b0;
    end else begin
      vote_q <= voteNext;
      if (tick) begin
        sampCnt_q <= (sampCnt_q == lastSamp) ? 4'h0 :
                     4'(sampCnt_q + 4'h1);
      end
      case (state_q)
        S_IDLE: begin
          sampCnt_q <= 4'h0;
          if (startDetect) begin
            state_q <= S_START;
          end
        end
        S_START: begin
          if (bitDone) begin
            // False start when centre reads high
            state_q <= bitVal ? S_IDLE : S_BITS;
            bitIdx_q <= 4'h0;
          end
        end
        S_BITS: begin
          if (bitDone) begin
            if (bitIdx_q < nBits) begin
              shift_q[bitIdx_q] <= bitVal;
            end else begin
              parRx_q <= bitVal;
            end
            bitIdx_q <= 4'(bitIdx_q + 4'h1);
            if (bitIdx_q == 4'(nBits - (parEn ? 4'h0 : 4'h1))) begin
              state_q <= S_STOP;
            end
          end
        end
        S_STOP: begin
          if (bitDone) begin
            // Second stop bit ignored; idle looks for the next start
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  // Shift register holds a frame that could not enter a full buffer
  logic bufFull;
  assign bufFull = (count_q == 2'h2);
  logic pushNow;
  assign pushNow = accept && (!bufFull || (rdData && !shiftFull_q));
  always_ff @(posedge clock) begin
    if (!rst_n || !receiver_enable_bit) begin
      shiftFull_q <= 1'b0;
      pendLost_q <= 1'b0;
    end else begin
      if (accept && !pushNow) begin
        shiftFull_q <= 1'b1;
      end else if (shiftFull_q && rdData) begin
        shiftFull_q <= 1'b0;
      end
      if (startDetect && bufFull && shiftFull_q) begin
        pendLost_q <= 1'b1;
      end else if (pushNow || (shiftFull_q && rdData)) begin
        pendLost_q <= 1'b0;
      end
    end
  end

  // Held frame waiting for space, captured when it cannot enter
  srx_entry_t held_q;
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      held_q <= '0;
    end else if (accept && !pushNow) begin
      held_q <= newEntry;
    end
  end

  // Receive buffer; a read pops the head, flushed when disabled
  always_ff @(posedge clock) begin
    if (!rst_n || !receiver_enable_bit) begin
      count_q <= 2'h0;
      head_q <= 1'b0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else begin
      if (pushNow) begin
        buf_q[1'(head_q + count_q[0])]
          <= newEntry;
      end else if (shiftFull_q && rdData) begin
        buf_q[head_q] <= held_q;
      end
      if (rdData && count_q != 2'h0) begin
        head_q <= !head_q;
      end
      if ((pushNow || (shiftFull_q && rdData)) &&
          !(rdData && count_q != 2'h0)) begin
        count_q <= 2'(count_q + 2'h1);
      end else if (!(pushNow || (shiftFull_q && rdData)) &&
                   rdData && count_q != 2'h0) begin
        count_q <= 2'(count_q - 2'h1);
      end
    end
  end

  // Software registers; filter bit only steers the receiver
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrlB_q <= 8'h00;
      fmtC_q <= FORMAT_C_RESET;
      baud_q <= 12'h000;
      double_q <= STATUS_A_RESET[BIT_DOUBLE];
      addrFilt_q <= STATUS_A_RESET[BIT_ADDR_FILT];
      txDone_q <= STATUS_A_RESET[BIT_TX_DONE];
      txEmpty_q <= STATUS_A_RESET[BIT_TX_EMPTY];
    end else begin
      txEmpty_q <= txBufferEmpty;
      if (txCompleteSet) begin
        txDone_q <= 1'b1; // Set wins over write-one clear
      end else if (wrEn && req.addr == ADDR_STATUS_A &&
                   req.wdata[BIT_TX_DONE]) begin
        txDone_q <= 1'b0;
      end
      if (wrEn) begin
        case (req.addr)
          ADDR_STATUS_A: begin
            double_q <= req.wdata[BIT_DOUBLE];
            addrFilt_q <= req.wdata[BIT_ADDR_FILT];
          end
          ADDR_CONTROL_B: ctrlB_q <= {req.wdata[7:2], 1'b0, req.wdata[0]};
          ADDR_FORMAT_C: fmtC_q <= req.wdata[7:0];
          ADDR_BAUD_LO: baud_q[7:0] <= req.wdata[7:0];
          ADDR_BAUD_HI: baud_q[11:8] <= req.wdata[3:0];
          default: begin
          end
        endcase
      end
    end
  end

  // Status A view of the head entry
  srx_entry_t head;
  logic haveData;
  assign head = buf_q[head_q];
  assign haveData = (count_q != 2'h0);
  logic [7:0] statusA;
  always_comb begin
    statusA = 8'h00;
    statusA[BIT_RX_DONE] = haveData;
    statusA[BIT_TX_DONE] = txDone_q;
    statusA[BIT_TX_EMPTY] = txEmpty_q;
    statusA[BIT_FRAME_ERR] = haveData && head.frameErr;
    statusA[BIT_OVERRUN] = haveData ? head.lost : pendLost_q;
    statusA[BIT_PAR_ERR] = haveData && head.parErr;
    statusA[BIT_DOUBLE] = double_q;
    statusA[BIT_ADDR_FILT] = addrFilt_q;
  end

  // APB answer: one wait state, read data registered
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= req.sel && req.enable && !pready_q;
      if (req.sel && req.enable && !pready_q && !req.write) begin
        case (req.addr)
          ADDR_STATUS_A: prdata_q <= {24'h000000, statusA};
          ADDR_CONTROL_B: prdata_q <= {24'h000000, ctrlB_q[7:2],
                                       head.data[8], ctrlB_q[0]};
          ADDR_FORMAT_C: prdata_q <= {24'h000000, fmtC_q};
          ADDR_BAUD_LO: prdata_q <= {24'h000000, baud_q[7:0]};
          ADDR_BAUD_HI: prdata_q <= {28'h0000000, baud_q[11:8]};
          ADDR_DATA: prdata_q <= {24'h000000, head.data[7:0]};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Pin ownership follows the enable
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pinOwned <= 1'b0;
    end else begin
      pinOwned <= receiver_enable_bit;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = 1'b0;

endmodule

// >>> tb/srx_receiver_props.sv
`timescale 1ns/1ps
module srx_receiver_props
  import srx_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // Pin ownership
  input wire logic pinOwned
);
  // Write lands at the edge where pready is seen
  logic wr;
  logic rdSt;
  logic enQ;
  logic [1:0] modeQ;
  logic [7:0] fmtQ;
  assign wr = psel && penable && pready && pwrite;
  assign rdSt = pready && !pwrite && paddr == ADDR_STATUS_A;
  // Shadow of the receiver enable
  always_ff @(posedge clock) begin
    if (!rst_n) enQ <= 1'b0;
    else if (wr && paddr == ADDR_CONTROL_B) enQ <= pwdata[BIT_RX_ENABLE];
  end
  // Shadow of speed and filter bits
  always_ff @(posedge clock) begin
    if (!rst_n) modeQ <= 2'h0;
    else if (wr && paddr == ADDR_STATUS_A) modeQ <= pwdata[1:0];
  end
  // Shadow of the format register
  always_ff @(posedge clock) begin
    if (!rst_n) fmtQ <= FORMAT_C_RESET;
    else if (wr && paddr == ADDR_FORMAT_C) fmtQ <= pwdata[7:0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_answer_time: assert property ($rose(penable) && psel |=> pready)
    else $error("answer not one cycle after access");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_mode_bits: assert property (rdSt |-> prdata[1:0] == modeQ)
    else $error("speed or filter bit wrong");
  a_format_back: assert property (pready && !pwrite && paddr == ADDR_FORMAT_C
    |-> prdata[7:0] == fmtQ)
    else $error("format readback wrong");
  a_pin_owner: assert property (enQ == $past(enQ) && enQ == $past(enQ, 2)
    |-> pinOwned == enQ)
    else $error("pin ownership differs from enable");
  a_flush_empty: assert property (rdSt && !enQ && !$past(enQ)
    |-> !prdata[BIT_RX_DONE])
    else $error("disabled receiver shows data");
  a_empty_flags: assert property (rdSt && !prdata[BIT_RX_DONE]
    |-> !prdata[BIT_FRAME_ERR] && !prdata[BIT_PAR_ERR])
    else $error("error flag with empty buffer");
endmodule
bind srx_receiver srx_receiver_props i_props (.clock, .rst_n, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pinOwned);

// >>> tb/srx_tx_model.sv
`timescale 1ns/1ps
module srx_tx_model (
  // Bit timing reference
  input wire logic clock,
  // Line toward the receiver, idle high
  output logic serialLine
);
  initial serialLine = 1'b1;
  // One frame lsb first; par 0 none, 2 even, 3 odd; bad flips parity
  task automatic sendFrame(input logic [8:0] d, input int nBits,
      input int par, input logic bad, input logic s1, input int stops,
      input int bitLen);
    logic [12:0] f;
    int n;
    f = 13'h1FFF;
    f[0] = 1'b0;
    for (int i = 0; i < nBits; i++) f[1 + i] = d[i];
    n = 1 + nBits;
    if (par > 1) begin
      f[n] = ^(d & ((9'h1 << nBits) - 9'h1)) ^ par[0] ^ bad;
      n++;
    end
    // First stop may carry the frame type marker
    f[n] = s1;
    n = n + stops;
    for (int i = 0; i < n; i++) begin
      serialLine <= f[i];
      repeat (bitLen) @(posedge clock);
    end
    // Back to idle only when the last bit left the line low
    if (f[n - 1] == 1'b0) serialLine <= 1'b1;
  endtask
endmodule

// >>> tb/srx_receiver_tb.sv
`timescale 1ns/1ps
module srx_receiver_tb import srx_pkg::*;;
  // Design stimulus and response
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr;
  logic serialIn, pinOwned, txCompleteSet, txBufferEmpty;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, st;
  logic sawOverrun;
  int nFail, nTests, cyc;
  srx_receiver i_dut (.clock, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .serialIn, .pinOwned,
    .txCompleteSet, .txBufferEmpty);
  srx_tx_model i_tx (.clock, .serialLine(serialIn));
  always #50 clock = ~clock;
  // Hang guard, well above the run length
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      nFail++;
      printVerdict();
    end
  end
  task printVerdict();
    $display("tests %0d mismatches %0d", nTests, nFail);
    if (nFail == 0 && nTests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      nFail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One bus transfer; held until pready is sampled
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll status until a frame shows, bounded
  task rxOne();
    for (int k = 0; k < 30; k++) begin
      apb(0, ADDR_STATUS_A, 0, st);
      if (st[7] === 1'b1) break;
    end
  endtask
  initial begin
    {clock, rst_n, psel, penable, pwrite, txCompleteSet} = 6'h0;
    {paddr, pwdata, nFail, nTests, cyc} = '0;
    txBufferEmpty = 1'b1;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    apb(0, ADDR_STATUS_A, 0, rd); chk(rd, 32'h20);
    apb(0, 8'hC3, 0, rd); chk(rd, 32'h0);
    chk({31'h0, pslverr}, 32'h0);
    // Transmit-complete is set by its pulse, cleared by writing one
    txCompleteSet <= 1'b1;
    @(posedge clock);
    txCompleteSet <= 1'b0;
    apb(0, ADDR_STATUS_A, 0, rd); chk(rd, 32'h60);
    apb(1, ADDR_STATUS_A, 32'h40, rd);
    apb(0, ADDR_STATUS_A, 0, rd); chk(rd, 32'h20);
    apb(1, ADDR_BAUD_LO, 32'h1, rd);
    apb(1, ADDR_BAUD_HI, 32'h0, rd);
    apb(1, ADDR_CONTROL_B, 32'h10, rd);
    // Sender three percent slow
    i_tx.sendFrame(9'hA5, 8, 0, 0, 1, 1, 33);
    rxOne(); chk(st, 32'hA0);
    apb(0, ADDR_DATA, 0, rd); chk(rd, 32'hA5);
    // Even and odd, good and bad parity
    for (int m = 2; m < 4; m++) for (int b = 0; b < 2; b++) begin
      apb(1, ADDR_FORMAT_C, 32'(32'h06 | (m << 4)), rd);
      i_tx.sendFrame(9'h3D, 8, m, b[0], 1, 1, 32);
      rxOne(); chk(st, 32'(32'hA0 | (b << 2)));
      apb(0, ADDR_DATA, 0, rd); chk(rd, 32'h3D);
    end
    apb(1, ADDR_FORMAT_C, 32'h06, rd);
    i_tx.sendFrame(9'h5A, 8, 0, 0, 0, 1, 32);
    rxOne(); chk(st, 32'hB0);
    apb(0, ADDR_DATA, 0, rd); chk(rd, 32'h5A);
    // Four frames unread: the newest replaces the one waiting
    for (int i = 0; i < 4; i++) begin
      i_tx.sendFrame(9'(8'h10 + i), 8, 0, 0, 1, 1, 32);
    end
    sawOverrun = 1'b0;
    for (int i = 0; i < 3; i++) begin
      apb(0, ADDR_STATUS_A, 0, st);
      sawOverrun = sawOverrun | st[3];
      apb(0, ADDR_DATA, 0, rd); chk(rd, 32'(8'h10 + i + i / 2));
    end
    chk({31'h0, sawOverrun}, 32'h1);
    i_tx.sendFrame(9'h21, 8, 0, 0, 1, 1, 32);
    rxOne(); chk(st, 32'hA0);
    apb(0, ADDR_DATA, 0, rd); chk(rd, 32'h21);
    // Disable with one frame buffered and one in flight
    i_tx.sendFrame(9'h77, 8, 0, 0, 1, 1, 32);
    rxOne();
    fork
      i_tx.sendFrame(9'h66, 8, 0, 0, 1, 1, 32);
      begin
        repeat (100) @(posedge clock);
        apb(1, ADDR_CONTROL_B, 32'h0, rd);
      end
    join
    chk({31'h0, pinOwned}, 32'h0);
    apb(1, ADDR_CONTROL_B, 32'h10, rd);
    apb(0, ADDR_STATUS_A, 0, st); chk(st, 32'h20);
    // Double speed halves the bit time
    apb(1, ADDR_STATUS_A, 32'h2, rd);
    i_tx.sendFrame(9'h81, 8, 0, 0, 1, 1, 16);
    rxOne(); chk(st, 32'hA2);
    apb(0, ADDR_DATA, 0, rd); chk(rd, 32'h81);
    // Nine bit frames with the filter on, then off
    apb(1, ADDR_CONTROL_B, 32'h14, rd);
    apb(1, ADDR_STATUS_A, 32'h1, rd);
    i_tx.sendFrame(9'h042, 9, 0, 0, 1, 1, 32);
    i_tx.sendFrame(9'h1A7, 9, 0, 0, 1, 1, 32);
    rxOne(); chk(st, 32'hA1);
    apb(0, ADDR_CONTROL_B, 0, rd); chk(rd, 32'h16);
    apb(0, ADDR_DATA, 0, rd); chk(rd, 32'hA7);
    apb(1, ADDR_STATUS_A, 32'h0, rd);
    i_tx.sendFrame(9'h042, 9, 0, 0, 1, 1, 32);
    rxOne(); chk(st, 32'hA0);
    apb(0, ADDR_DATA, 0, rd); chk(rd, 32'h42);
    // Eight bit frames, marker in the first of two stops
    apb(1, ADDR_CONTROL_B, 32'h10, rd);
    apb(1, ADDR_STATUS_A, 32'h1, rd);
    i_tx.sendFrame(9'h33, 8, 0, 0, 0, 2, 32);
    i_tx.sendFrame(9'h44, 8, 0, 0, 1, 2, 32);
    rxOne(); chk(st, 32'hA1);
    apb(0, ADDR_DATA, 0, rd); chk(rd, 32'h44);
    printVerdict();
  end
endmodule
